// ### src/capcmp_pkg.sv
// capcmp_pkg: register map, field positions and reset values of the capture/compare timer block
// assumes a 32-bit AHB-Lite register bus with each 8-bit register in the low byte of its own word
package capcmp_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    // channel block: capture high, capture low, compare high, compare low
    localparam logic [7:0] CHAN_BASE_ADDR = 8'h0c;
    localparam logic [7:0] CHAN_STRIDE = 8'h10;
    localparam logic [7:0] CAP_HI_OFS = 8'h00;
    localparam logic [7:0] CAP_LO_OFS = 8'h04;
    localparam logic [7:0] CMP_HI_OFS = 8'h08;
    localparam logic [7:0] CMP_LO_OFS = 8'h0c;
    localparam logic [7:0] COUNT_HI_ADDR = 8'h2c;
    localparam logic [7:0] COUNT_LO_ADDR = 8'h30;

    // ----------------------------------------------------------------
    // control one fields
    // ----------------------------------------------------------------
    localparam int CAP_IRQ_EN_BIT = 7;
    localparam int CMP_IRQ_EN_BIT = 6;
    localparam int FORCE_TWO_BIT = 4;
    localparam int FORCE_ONE_BIT = 3;
    localparam int LEVEL_TWO_BIT = 2;
    localparam int EDGE_ONE_BIT = 1;
    localparam int LEVEL_ONE_BIT = 0;

    // ----------------------------------------------------------------
    // control two fields
    // ----------------------------------------------------------------
    localparam int PIN_EN_ONE_BIT = 7;
    localparam int PIN_EN_TWO_BIT = 6;
    localparam int PULSE_SEL_BIT = 5;
    localparam int PWM_SEL_BIT = 4;
    localparam int CLK_SEL_HI_BIT = 3;
    localparam int CLK_SEL_LO_BIT = 2;
    localparam int EDGE_TWO_BIT = 1;

    // ----------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------
    localparam int CAP_FLAG_ONE_BIT = 7;
    localparam int CMP_FLAG_ONE_BIT = 6;
    localparam int OVF_FLAG_BIT = 5;
    localparam int CAP_FLAG_TWO_BIT = 4;
    localparam int CMP_FLAG_TWO_BIT = 3;

    // ----------------------------------------------------------------
    // values
    // ----------------------------------------------------------------
    localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [1:0] DIV_BY_2 = 2'h0;
    localparam logic [1:0] DIV_BY_4 = 2'h1;
    localparam logic [2:0] DIV_LIMIT_2 = 3'h1;
    localparam logic [2:0] DIV_LIMIT_4 = 3'h3;
    localparam logic [2:0] DIV_LIMIT_8 = 3'h7;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACCESS = 1'b1
    } bus_state_e;

endpackage : capcmp_pkg

// ### src/timer_capture_compare.sv
// timer_capture_compare: 16-bit timer with two capture and two compare channels and one pulse mode
// assumes one 10 MHz clock, AHB-Lite with a single slave, capture pins asynchronous to clk
//
// What this block does
// RL1 - capture latches counter on active pin edge
// RL2 - software bit picks each capture edge
// RL3 - capture sets flag, interrupt when enabled, unmasked
// RL4 - capture flag clears: status read, low access
// RL5 - high byte read blocks capture until low
// RL6 - pwm mode: only channel two captures
// RL7 - capture pins always watched, even as outputs
// RL8 - capture flag two to three clocks late
// RL9 - compare match sets flag, drives enabled pin
// RL10 - compare registers software only, reset 8000h
// RL11 - compare pin latches low during reset
// RL12 - compare interrupt needs enable and clear mask
// RL13 - high write suspends compare until low write
// RL14 - software writes high, reads status, writes low
// RL15 - disabled pin ignores match, interrupt still possible
// RL16 - match effect while counter equals compare value
// RL17 - force bit copies level, no flag
// RL18 - force bits ignored in pulse/pwm modes
// RL19 - pulse mode bit uses channel one pair
// RL20 - pulse trigger: capture, reload, level two, flag
// RL21 - pulse length from compare one, levels two/one
// RL22 - timer tick is clk divided 2/4/8
// RL23 - compare one match ends pulse, level one
// RL24 - pulse mode never sets compare flag one
// RL25 - counter resets and reloads to FFFCh
// RL26 - capture pins synchronised before edge detection
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

module timer_capture_compare
    import capcmp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // capture pins
    input wire logic [1:0] capture_input_pin,
    // compare pins, driven while the enable is high
    output logic [1:0] compare_output_pin,
    output logic [1:0] compare_output_enable,
    // cpu interrupt mask and shared timer interrupt
    input wire logic cpuIrqMask,
    output logic timerIrq
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] chanAddr(input int chan, input logic [7:0] ofs);
        chanAddr = 8'(CHAN_BASE_ADDR + CHAN_STRIDE * chan + ofs);
    endfunction : chanAddr

    bus_state_e busState;
    logic [7:0] accAddr, wdata, rdByte;
    logic accWriteSel, accRead, accWrite;

    logic [7:0] ctrlOne, ctrlTwo;
    logic [15:0] counter;
    logic [2:0] divCount, divLimit;
    logic ovfFlag, ovfArmed, tick, pulseMode, pwmMode;

    logic [1:0] capSync1, capSync2, capPrev, capEdgeSel, capEvent, capInhibit, capFlag, capArmed;
    logic [15:0] capValue [2], cmpValue [2];
    logic [1:0] cmpInhibit, cmpFlag, matchNow, matchPrev, pinEn, pinLatch, level, forceBit;
    logic [7:0] statusByte;

    assign accRead = (busState == BUS_ACCESS) && !accWriteSel;
    assign accWrite = (busState == BUS_ACCESS) && accWriteSel;
    assign wdata = hwdata[7:0];
    assign pwmMode = ctrlTwo[PWM_SEL_BIT];
    // pwm wins when both mode bits are set
    assign pulseMode = ctrlTwo[PULSE_SEL_BIT] && !pwmMode; // see RL19
    assign level = {ctrlOne[LEVEL_TWO_BIT], ctrlOne[LEVEL_ONE_BIT]};
    assign forceBit = {wdata[FORCE_TWO_BIT], wdata[FORCE_ONE_BIT]};
    assign pinEn = {ctrlTwo[PIN_EN_TWO_BIT], ctrlTwo[PIN_EN_ONE_BIT]};
    assign capEdgeSel = {ctrlTwo[EDGE_TWO_BIT], ctrlOne[EDGE_ONE_BIT]}; // see RL2

    // ----------------------------------------------------------------
    // bus slave: one wait state so that read data leave a flip-flop
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            busState <= BUS_IDLE;
            accAddr <= 8'h00;
            accWriteSel <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            unique case (busState)
                BUS_IDLE: begin
                    if (hsel && htrans[1] && hready) begin
                        busState <= BUS_ACCESS;
                        accAddr <= haddr[7:0];
                        accWriteSel <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                BUS_ACCESS: begin
                    busState <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    assign statusByte = 8'(capFlag[0]) << CAP_FLAG_ONE_BIT | 8'(cmpFlag[0]) << CMP_FLAG_ONE_BIT
                      | 8'(ovfFlag) << OVF_FLAG_BIT | 8'(capFlag[1]) << CAP_FLAG_TWO_BIT
                      | 8'(cmpFlag[1]) << CMP_FLAG_TWO_BIT;

    always_comb begin
        rdByte = 8'h00;
        unique case (accAddr)
            CTRL_ONE_ADDR: rdByte = ctrlOne;
            CTRL_TWO_ADDR: rdByte = ctrlTwo;
            STATUS_ADDR: rdByte = statusByte;
            chanAddr(0, CAP_HI_OFS): rdByte = capValue[0][15:8];
            chanAddr(0, CAP_LO_OFS): rdByte = capValue[0][7:0];
            chanAddr(0, CMP_HI_OFS): rdByte = cmpValue[0][15:8];
            chanAddr(0, CMP_LO_OFS): rdByte = cmpValue[0][7:0];
            chanAddr(1, CAP_HI_OFS): rdByte = capValue[1][15:8];
            chanAddr(1, CAP_LO_OFS): rdByte = capValue[1][7:0];
            chanAddr(1, CMP_HI_OFS): rdByte = cmpValue[1][15:8];
            chanAddr(1, CMP_LO_OFS): rdByte = cmpValue[1][7:0];
            COUNT_HI_ADDR: rdByte = counter[15:8];
            COUNT_LO_ADDR: rdByte = counter[7:0];
            default: rdByte = 8'h00;
        endcase
    end

    // unmapped addresses read as zero and ignore writes
    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (accRead) begin
            hrdata <= {24'h00_0000, rdByte};
        end
    end

    // force bits are actions, so they are never stored
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlOne <= 8'h00;
            ctrlTwo <= 8'h00;
        end else if (accWrite) begin
            if (accAddr == CTRL_ONE_ADDR) begin
                ctrlOne <= wdata & ~(8'h01 << FORCE_ONE_BIT) & ~(8'h01 << FORCE_TWO_BIT);
            end
            if (accAddr == CTRL_TWO_ADDR) begin
                ctrlTwo <= wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // prescaler and free-running counter
    // ----------------------------------------------------------------
    always_comb begin
        unique case (ctrlTwo[CLK_SEL_HI_BIT:CLK_SEL_LO_BIT])
            DIV_BY_2: divLimit = DIV_LIMIT_2;
            DIV_BY_4: divLimit = DIV_LIMIT_4;
            default: divLimit = DIV_LIMIT_8;
        endcase
    end

    assign tick = (divCount >= divLimit); // see RL22

    always_ff @(posedge clk) begin
        if (reset || tick) begin
            divCount <= 3'h0;
        end else begin
            divCount <= divCount + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            counter <= COUNT_RELOAD; // see RL25
        end else if ((accWrite && accAddr == COUNT_LO_ADDR) || (pulseMode && capEvent[0])) begin
            counter <= COUNT_RELOAD; // see RL25, RL20
        end else if (tick) begin
            counter <= counter + 16'h0001;
        end
    end

    // overflow flag clears like the capture flags; a new overflow wins
    always_ff @(posedge clk) begin
        if (reset) begin
            ovfFlag <= 1'b0;
            ovfArmed <= 1'b0;
        end else if (tick && counter == COUNT_TOP) begin
            ovfFlag <= 1'b1;
            ovfArmed <= 1'b0;
        end else if (accRead && accAddr == STATUS_ADDR && ovfFlag) begin
            ovfArmed <= 1'b1;
        end else if (ovfArmed && (accRead || accWrite) && accAddr == COUNT_LO_ADDR) begin
            ovfFlag <= 1'b0;
            ovfArmed <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // per-channel capture and compare
    // ----------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : gChan
        logic edgeSeen, capAllowed, capLoAccess;

        // the first stage feeds only the second stage
        always_ff @(posedge clk) begin
            if (reset) begin
                capSync1[ch] <= 1'b0;
                capSync2[ch] <= 1'b0;
                capPrev[ch] <= 1'b0;
            end else begin
                capSync1[ch] <= capture_input_pin[ch]; // see RL26
                capSync2[ch] <= capSync1[ch];
                capPrev[ch] <= capSync2[ch];
            end
        end

        // pins stay connected whether or not the port is an output
        assign edgeSeen = capEdgeSel[ch] ? (capSync2[ch] && !capPrev[ch])
                                         : (!capSync2[ch] && capPrev[ch]); // see RL7, RL2
        // in pwm mode the first capture pin is not a capture input
        assign capAllowed = (ch == 1) || !pwmMode; // see RL6
        assign capEvent[ch] = edgeSeen && capAllowed && !capInhibit[ch]; // see RL5, RL8
        assign capLoAccess = (accRead || accWrite) && accAddr == chanAddr(ch, CAP_LO_OFS);

        always_ff @(posedge clk) begin
            if (reset) begin
                capValue[ch] <= 16'h0000;
            end else if (capEvent[ch]) begin
                capValue[ch] <= counter; // see RL1
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                capInhibit[ch] <= 1'b0;
            end else if (accRead && accAddr == chanAddr(ch, CAP_HI_OFS)) begin
                capInhibit[ch] <= 1'b1; // see RL5
            end else if (accRead && accAddr == chanAddr(ch, CAP_LO_OFS)) begin
                capInhibit[ch] <= 1'b0;
            end
        end

        // a capture arriving with the clearing access keeps the flag set
        always_ff @(posedge clk) begin
            if (reset) begin
                capFlag[ch] <= 1'b0;
                capArmed[ch] <= 1'b0;
            end else if (capEvent[ch]) begin
                capFlag[ch] <= 1'b1; // see RL3
                capArmed[ch] <= 1'b0;
            end else if (accRead && accAddr == STATUS_ADDR && capFlag[ch]) begin
                capArmed[ch] <= 1'b1; // see RL4
            end else if (capArmed[ch] && capLoAccess) begin
                capFlag[ch] <= 1'b0; // see RL4
                capArmed[ch] <= 1'b0;
            end
        end

        // compare registers are changed only by software
        always_ff @(posedge clk) begin
            if (reset) begin
                cmpValue[ch] <= CMP_RESET; // see RL10
                cmpInhibit[ch] <= 1'b0;
            end else if (accWrite && accAddr == chanAddr(ch, CMP_HI_OFS)) begin
                cmpValue[ch][15:8] <= wdata;
                cmpInhibit[ch] <= 1'b1; // see RL13
            end else if (accWrite && accAddr == chanAddr(ch, CMP_LO_OFS)) begin
                cmpValue[ch][7:0] <= wdata;
                cmpInhibit[ch] <= 1'b0; // see RL13
            end
        end

        // a timer count lasts at least two clocks, so acting on the first clock of equality
        // lands inside the count where the counter equals the compare value
        assign matchNow[ch] = (counter == cmpValue[ch]) && !cmpInhibit[ch]; // see RL9, RL16

        always_ff @(posedge clk) begin
            if (reset) begin
                matchPrev[ch] <= 1'b0;
            end else begin
                matchPrev[ch] <= matchNow[ch];
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                cmpFlag[ch] <= 1'b0;
            end else if (matchNow[ch] && !matchPrev[ch] && !pwmMode && !(ch == 0 && pulseMode)) begin
                cmpFlag[ch] <= 1'b1; // see RL9, RL24
            end else if (accWrite && accAddr == chanAddr(ch, CMP_LO_OFS)) begin
                cmpFlag[ch] <= 1'b0; // see RL13
            end
        end
    end

    // ----------------------------------------------------------------
    // compare pins
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            pinLatch <= 2'b00; // see RL11
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (ch == 0 && pulseMode) begin
                    if (capEvent[0] && pinEn[0]) begin
                        pinLatch[0] <= level[1]; // see RL20, RL21
                    end else if (matchNow[0] && !matchPrev[0] && pinEn[0]) begin
                        pinLatch[0] <= level[0]; // see RL23, RL21
                    end
                end else if (pulseMode || pwmMode) begin
                    // level two belongs to the pulse, so pin two holds
                    pinLatch[ch] <= pinLatch[ch];
                end else if (accWrite && accAddr == CTRL_ONE_ADDR && forceBit[ch] && pinEn[ch]) begin
                    pinLatch[ch] <= ch == 0 ? wdata[LEVEL_ONE_BIT] : wdata[LEVEL_TWO_BIT]; // see RL17, RL18
                end else if (matchNow[ch] && !matchPrev[ch] && pinEn[ch]) begin
                    pinLatch[ch] <= level[ch]; // see RL9, RL15
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            compare_output_pin <= 2'b00;
            compare_output_enable <= 2'b00;
        end else begin
            compare_output_pin <= pinLatch;
            compare_output_enable <= pinEn; // see RL15
        end
    end

    // ----------------------------------------------------------------
    // shared timer interrupt, pending flags wait for enable and mask
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            timerIrq <= 1'b0;
        end else begin
            timerIrq <= !cpuIrqMask && ((ctrlOne[CAP_IRQ_EN_BIT] && |capFlag)
                                     || (ctrlOne[CMP_IRQ_EN_BIT] && |cmpFlag)); // see RL3, RL12
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence pulseTrigger;
        pulseMode && capEvent[0] && pinEn[0];
    endsequence

    sequence pulseStarted;
        counter == COUNT_RELOAD && pinLatch[0] == $past(level[1]) && capFlag[0];
    endsequence

    capture_flag_a: assert property (capEvent[1] |=> capFlag[1] && capValue[1] == $past(counter)) // see RL1
        else $error("capture did not latch counter and flag");
    capture_delay_a: assert property (capEvent[0] |-> $past(capture_input_pin[0], 2)
                                                      != $past(capture_input_pin[0], 3)) // see RL8
        else $error("capture not two clocks after pin edge");
    capture_block_a: assert property (capInhibit[1] && !capFlag[1] |=> $stable(capValue[1]) && !capFlag[1]) // see RL5
        else $error("capture happened while high byte read pending");
    compare_reset_a: assert property ($past(reset) |-> cmpValue[0] == CMP_RESET && pinLatch == 2'b00) // see RL10
        else $error("compare reset value wrong");
    compare_hold_a: assert property (cmpInhibit[1] && !cmpFlag[1] |=> !cmpFlag[1]) // see RL13
        else $error("compare flag set while suspended");
    pin_disabled_a: assert property (!pinEn[1] |=> $stable(pinLatch[1])) // see RL15
        else $error("disabled compare pin changed");
    pulse_start_a: assert property (pulseTrigger |=> pulseStarted) // see RL20
        else $error("pulse trigger did not reload and drive level two");
    pulse_flag_a: assert property (pulseMode && !cmpFlag[0] |=> !cmpFlag[0]) // see RL24
        else $error("compare flag one set in pulse mode");
    irq_raise_a: assert property (ctrlOne[CAP_IRQ_EN_BIT] && |capFlag && !cpuIrqMask
                                  ##1 !cpuIrqMask |-> timerIrq) // see RL3
        else $error("capture interrupt not raised");
    tick_period_a: assert property (tick ##1 $stable(divLimit) [*1] |-> !tick) // see RL22
        else $error("timer tick faster than divide by two");
endmodule : timer_capture_compare

// ### sim/capcmp_pin_model.sv
// capcmp_pin_model: outside world of the capture and compare pins
// assumes the testbench calls setPin off the clock edge owner, one pin change per call
`timescale 1ns/1ps

module capcmp_pin_model (
    // clock
    input wire logic clk,
    // pins
    output logic [1:0] capPin,
    input wire logic [1:0] cmpPin
);
    initial capPin = 2'h0;

    // level held for 4 clocks so the 2-clock minimum width is always met
    task setPin(input int ch, input logic lvl);
        capPin[ch] <= lvl;
        repeat (4) @(posedge clk);
    endtask : setPin
endmodule : capcmp_pin_model

// ### sim/timer_capture_compare_tb.sv
// timer_capture_compare_tb: register-level tests of capture, compare, force and single pulse
// assumes a single AHB-Lite slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end

module timer_capture_compare_tb;
    import capcmp_pkg::*;
    logic clk = 0, reset = 1, hsel = 0, hwrite = 0, hreadyout, hresp, cpuIrqMask = 0, timerIrq;
    logic [1:0] htrans = 2'h0, cmpPin, cmpEn, capPin;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [7:0] rd;
    int num_errors = 0, tests_run = 0;

    always #50 clk = ~clk;

    timer_capture_compare timer_capture_compare_inst (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(capPin), .compare_output_pin(cmpPin),
        .compare_output_enable(cmpEn), .cpuIrqMask(cpuIrqMask), .timerIrq(timerIrq));
    capcmp_pin_model capcmp_pin_model_inst (.clk(clk), .capPin(capPin), .cmpPin(cmpPin));

    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic waitReady;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin num_errors++; stop_test(); end
            @(posedge clk);
        end
    endtask : waitReady

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        waitReady();
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= {24'h0, d};
        waitReady();
        rd = hrdata[7:0];
    endtask : bus

    // bounded wait until a compare pin shows a level
    task automatic waitPin(input int ch, input logic lvl);
        int n;
        for (n = 0; n < 400 && cmpPin[ch] !== lvl; n++) @(posedge clk);
        `CHK("cmpPin", lvl, cmpPin[ch])
        if (cmpPin[ch] !== lvl) stop_test();
    endtask : waitPin

    initial begin
        // ------------------------------------------------------------
        // reset values
        // ------------------------------------------------------------
        repeat (4) @(posedge clk);
        `CHK("pinRst", 2'h0, cmpPin)
        `CHK("enRst", 2'h0, cmpEn)
        reset <= 1'b0;
        bus(0, 8'h14, 8'h0); `CHK("cmp1hi", 8'h80, rd)
        bus(0, 8'h18, 8'h0); `CHK("cmp1lo", 8'h00, rd)
        bus(0, 8'h24, 8'h0); `CHK("cmp2hi", 8'h80, rd)
        bus(0, 8'h40, 8'h0); `CHK("unmapped", 8'h00, rd)
        `CHK("hresp", 1'b0, hresp)
        // ------------------------------------------------------------
        // compare two: match drives pin, sets flag, irq; low write clears
        // ------------------------------------------------------------
        bus(1, 8'h04, 8'h42);
        bus(1, 8'h00, 8'h44);
        bus(1, 8'h24, 8'h00);
        bus(0, 8'h08, 8'h0);
        bus(1, 8'h28, 8'h30);
        waitPin(1, 1'b1);
        bus(0, 8'h08, 8'h0); `CHK("cmpFlag2", 1'b1, rd[CMP_FLAG_TWO_BIT])
        `CHK("irqCmp", 1'b1, timerIrq)
        bus(1, 8'h28, 8'h30);
        bus(0, 8'h08, 8'h0); `CHK("cmpClr2", 1'b0, rd[CMP_FLAG_TWO_BIT])
        // ------------------------------------------------------------
        // capture two: blocked after high read, two-step clear
        // ------------------------------------------------------------
        bus(1, 8'h00, 8'h80);
        bus(0, 8'h1c, 8'h0);
        capcmp_pin_model_inst.setPin(1, 1'b1);
        bus(0, 8'h08, 8'h0); `CHK("capBlocked", 1'b0, rd[CAP_FLAG_TWO_BIT])
        bus(0, 8'h20, 8'h0);
        capcmp_pin_model_inst.setPin(1, 1'b0);
        capcmp_pin_model_inst.setPin(1, 1'b1);
        @(posedge clk);
        `CHK("irqCap", 1'b1, timerIrq)
        cpuIrqMask <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("irqMasked", 1'b0, timerIrq)
        cpuIrqMask <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("irqPending", 1'b1, timerIrq)
        bus(0, 8'h20, 8'h0);
        bus(0, 8'h08, 8'h0); `CHK("capFlag2", 1'b1, rd[CAP_FLAG_TWO_BIT])
        bus(0, 8'h20, 8'h0);
        bus(0, 8'h08, 8'h0); `CHK("capClr2", 1'b0, rd[CAP_FLAG_TWO_BIT])
        // ------------------------------------------------------------
        // force one, then single pulse on channel one
        // ------------------------------------------------------------
        bus(1, 8'h04, 8'hc2);
        bus(1, 8'h00, 8'h09);
        waitPin(0, 1'b1);
        `CHK("cmpEn", 2'h3, cmpEn)
        bus(0, 8'h08, 8'h0); `CHK("forceFlag", 1'b0, rd[CMP_FLAG_ONE_BIT])
        bus(1, 8'h00, 8'h08);
        waitPin(0, 1'b0);
        bus(1, 8'h14, 8'h00);
        bus(1, 8'h18, 8'h10);
        bus(1, 8'h00, 8'h06);
        bus(1, 8'h04, 8'ha0);
        capcmp_pin_model_inst.setPin(0, 1'b1);
        waitPin(0, 1'b1);
        waitPin(0, 1'b0);
        bus(0, 8'h08, 8'h0);
        `CHK("pulseCap1", 1'b1, rd[CAP_FLAG_ONE_BIT])
        `CHK("pulseCmp1", 1'b0, rd[CMP_FLAG_ONE_BIT])
        bus(1, 8'h00, 8'h0f);
        repeat (4) @(posedge clk);
        `CHK("forceOff", 1'b0, cmpPin[0])
        stop_test();
    end
endmodule : timer_capture_compare_tb
